// *** design/acf_top.sv ***
// Converter control, input selection and result formatting with an AXI4-Lite register slave
// Functional notes
// - Converter works only while enable is 1; otherwise held in shutdown.
// - Input multiplexer offers the 17 port pins to both the positive and negative selectors.
// - Positive side chooses a port pin, the temperature sensor or supply.
// - Negative side chooses a port pin, the reference voltage or ground.
// - Ground as negative input means single-ended; anything else differential.
// - High and low result bytes load the new code at each completion.
// - Control bit 0 selects right justify at 0, left justify at 1.
// - Single-ended results are 10-bit unsigned codes.
// - Single-ended unused bits are zero: full scale 0x03FF or 0xFFC0.
// - Differential results are 10-bit two's complement codes.
// - Right-justified differential results sign-extend the high byte.
// - Left-justified differential results clear the low unused bits.
// - Conversions never exceed 200 ksps, one 10-bit result each.
// - Temperature select routes the sensor to the positive input.
`timescale 1ns/10ps
module acf_top
	import acf_pkg::*;
(
	input  wire logic                                        clock,
	input  wire logic                                        rst_n,
	input  wire logic [acf_pkg::PIN_COUNT-1:0][acf_pkg::CODE_W-1:0] pin_level,
	input  wire logic [acf_pkg::CODE_W-1:0]                  temp_level,
	input  wire logic [acf_pkg::CODE_W-1:0]                  supply_level,
	input  wire logic [acf_pkg::ADDR_W-1:0]                  awaddr,
	input  wire logic                                        awvalid,
	output      logic                                        awready,
	input  wire logic [acf_pkg::DATA_W-1:0]                  wdata,
	input  wire logic [3:0]                                  wstrb,
	input  wire logic                                        wvalid,
	output      logic                                        wready,
	output      logic [1:0]                                  bresp,
	output      logic                                        bvalid,
	input  wire logic                                        bready,
	input  wire logic [acf_pkg::ADDR_W-1:0]                  araddr,
	input  wire logic                                        arvalid,
	output      logic                                        arready,
	output      logic [acf_pkg::DATA_W-1:0]                  rdata,
	output      logic [1:0]                                  rresp,
	output      logic                                        rvalid,
	input  wire logic                                        rready,
	output      logic                                        shutdown,
	output      logic                                        temp_sensor_route,
	output      logic                                        differential_mode
);

	// ****************************************************************
	// State
	// ****************************************************************
	logic                enable_bit,   next_enable_bit;
	logic                left_justify, next_left_justify;
	logic                done_flag,    next_done_flag;
	logic [SEL_W-1:0]    pos_sel,      next_pos_sel;
	logic [SEL_W-1:0]    neg_sel,      next_neg_sel;
	logic [7:0]          result_high,  next_result_high;
	logic [7:0]          result_low,   next_result_low;
	logic                conv_diff,    next_conv_diff;
	logic                conv_left,    next_conv_left;
	logic                next_shutdown;
	logic                next_temp_route;
	logic                next_diff_mode;
	logic                next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]          next_bresp,   next_rresp;
	logic [DATA_W-1:0]   next_rdata;
	logic [ADDR_W-1:0]   wr_addr,      next_wr_addr;
	logic [DATA_W-1:0]   wr_data,      next_wr_data;
	logic                wr_lane0,     next_wr_lane0;
	logic [LEVEL_W-1:0]  pos_lvl;
	logic [LEVEL_W-1:0]  neg_lvl;
	logic [LEVEL_W:0]    diff_lvl;
	acf_code_type        sample;
	logic [15:0]         word;

	acf_conv_if conv ();

	acf_conv_engine #(
		.CYCLES (CONV_CYCLES)
	) u_engine (
		.clock  (clock),
		.rst_n  (rst_n),
		.enable (enable_bit),
		.conv   (conv.engine)
	);

	// ****************************************************************
	// Input selection
	// ****************************************************************
	always_comb
	begin
		pos_lvl = LEVEL_GND;
		if (pos_sel < SEL_W'(PIN_COUNT))
			pos_lvl = {1'b0, pin_level[pos_sel]};
		else if (pos_sel == POS_SEL_TEMP)
			pos_lvl = {1'b0, temp_level};
		else if (pos_sel == POS_SEL_SUPPLY)
			pos_lvl = {1'b0, supply_level};
		neg_lvl = LEVEL_GND;
		if (neg_sel < SEL_W'(PIN_COUNT))
			neg_lvl = {1'b0, pin_level[neg_sel]};
		else if (neg_sel == NEG_SEL_VREF)
			neg_lvl = LEVEL_VREF;
		diff_lvl = {1'b0, pos_lvl} - {1'b0, neg_lvl};
		if (neg_sel == NEG_SEL_GND)
			sample = pos_lvl[CODE_W-1:0];
		else
			sample = diff_lvl[CODE_W:1];
	end

	assign conv.sample_code = sample;

	// ****************************************************************
	// Result formatting
	// ****************************************************************
	always_comb
	begin
		if (conv_left)
			word = {conv.result_code, {PAD_W{1'b0}}};
		else if (conv_diff)
			word = {{PAD_W{conv.result_code[CODE_W-1]}}, conv.result_code};
		else
			word = {{PAD_W{1'b0}}, conv.result_code};
	end

	// ****************************************************************
	// Register file and bus slave
	// ****************************************************************
	always_comb
	begin
		next_enable_bit   = enable_bit;
		next_left_justify = left_justify;
		next_done_flag    = done_flag;
		next_pos_sel      = pos_sel;
		next_neg_sel      = neg_sel;
		next_result_high  = result_high;
		next_result_low   = result_low;
		next_conv_diff    = conv_diff;
		next_conv_left    = conv_left;
		next_awready      = awready;
		next_wready       = wready;
		next_bvalid       = bvalid;
		next_bresp        = bresp;
		next_arready      = arready;
		next_rvalid       = rvalid;
		next_rresp        = rresp;
		next_rdata        = rdata;
		next_wr_addr      = wr_addr;
		next_wr_data      = wr_data;
		next_wr_lane0     = wr_lane0;
		conv.start        = 1'b0;

		if (awvalid && awready)
		begin
			next_awready = 1'b0;
			next_wr_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			next_wready   = 1'b0;
			next_wr_data  = wdata;
			next_wr_lane0 = wstrb[0];
		end

		if (!awready && !wready && !bvalid)
		begin
			next_bvalid = 1'b1;
			next_bresp  = RESP_OKAY;
			unique case (wr_addr)
				OFS_CONTROL:
				begin
					if (wr_lane0)
					begin
						next_left_justify = wr_data[BIT_LEFT_JUSTIFY];
						next_enable_bit   = wr_data[BIT_ENABLE];
						if (!wr_data[BIT_DONE])
							next_done_flag = 1'b0;
						if (wr_data[BIT_START_BUSY] && wr_data[BIT_ENABLE] && enable_bit
							&& !conv.busy)
						begin
							conv.start     = 1'b1;
							next_conv_diff = (neg_sel != NEG_SEL_GND);
							next_conv_left = wr_data[BIT_LEFT_JUSTIFY];
						end
					end
				end
				OFS_POS_SEL:
					if (wr_lane0)
						next_pos_sel = wr_data[SEL_W-1:0];
				OFS_NEG_SEL:
					if (wr_lane0)
						next_neg_sel = wr_data[SEL_W-1:0];
				OFS_RES_HIGH, OFS_RES_LOW, OFS_STATUS:
					next_bresp = RESP_OKAY;
				default:
					next_bresp = RESP_SLVERR;
			endcase
		end
		if (bvalid && bready)
		begin
			next_bvalid  = 1'b0;
			next_awready = 1'b1;
			next_wready  = 1'b1;
		end

		if (arvalid && arready)
		begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rresp   = RESP_OKAY;
			next_rdata   = '0;
			unique case (araddr)
				OFS_CONTROL:
				begin
					next_rdata[BIT_LEFT_JUSTIFY] = left_justify;
					next_rdata[BIT_START_BUSY]   = conv.busy;
					next_rdata[BIT_DONE]         = done_flag;
					next_rdata[BIT_ENABLE]       = enable_bit;
				end
				OFS_POS_SEL:  next_rdata[SEL_W-1:0] = pos_sel;
				OFS_NEG_SEL:  next_rdata[SEL_W-1:0] = neg_sel;
				OFS_RES_HIGH: next_rdata[7:0]       = result_high;
				OFS_RES_LOW:  next_rdata[7:0]       = result_low;
				OFS_STATUS:   next_rdata[BIT_DIFF_MODE] = (neg_sel != NEG_SEL_GND);
				default:      next_rresp = RESP_SLVERR;
			endcase
		end
		if (rvalid && rready)
		begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end

		if (conv.done)
		begin
			next_result_high = word[15:8];
			next_result_low  = word[7:0];
			next_done_flag   = 1'b1;
		end

		next_shutdown   = !next_enable_bit;
		next_temp_route = (next_pos_sel == POS_SEL_TEMP);
		next_diff_mode  = (next_neg_sel != NEG_SEL_GND);
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			enable_bit        <= 1'b0;
			left_justify      <= 1'b0;
			done_flag         <= 1'b0;
			pos_sel           <= SEL_RESET;
			neg_sel           <= SEL_RESET;
			result_high       <= BYTE_RESET;
			result_low        <= BYTE_RESET;
			conv_diff         <= 1'b0;
			conv_left         <= 1'b0;
			shutdown          <= 1'b1;
			temp_sensor_route <= 1'b0;
			differential_mode <= 1'b1;
			awready           <= 1'b1;
			wready            <= 1'b1;
			bvalid            <= 1'b0;
			bresp             <= RESP_OKAY;
			arready           <= 1'b1;
			rvalid            <= 1'b0;
			rresp             <= RESP_OKAY;
			rdata             <= '0;
			wr_addr           <= '0;
			wr_data           <= '0;
			wr_lane0          <= 1'b0;
		end
		else
		begin
			enable_bit        <= next_enable_bit;
			left_justify      <= next_left_justify;
			done_flag         <= next_done_flag;
			pos_sel           <= next_pos_sel;
			neg_sel           <= next_neg_sel;
			result_high       <= next_result_high;
			result_low        <= next_result_low;
			conv_diff         <= next_conv_diff;
			conv_left         <= next_conv_left;
			shutdown          <= next_shutdown;
			temp_sensor_route <= next_temp_route;
			differential_mode <= next_diff_mode;
			awready           <= next_awready;
			wready            <= next_wready;
			bvalid            <= next_bvalid;
			bresp             <= next_bresp;
			arready           <= next_arready;
			rvalid            <= next_rvalid;
			rresp             <= next_rresp;
			rdata             <= next_rdata;
			wr_addr           <= next_wr_addr;
			wr_data           <= next_wr_data;
			wr_lane0          <= next_wr_lane0;
		end
	end

endmodule : acf_top

// *** design/acf_pkg.sv ***
// Shared constants and types for the converter control and result formatting block
package acf_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLOCK_HZ         = 20_000_000;
	localparam int MAX_RATE_KSPS    = 200;
	localparam int CONV_CYCLES      = (CLOCK_HZ + MAX_RATE_KSPS * 1000 - 1) / (MAX_RATE_KSPS * 1000);
	localparam int CONV_CNT_W       = $clog2(CONV_CYCLES);

	// ****************************************************************
	// Widths and input counts
	// ****************************************************************
	localparam int CODE_W           = 10;
	localparam int LEVEL_W          = CODE_W + 1;
	localparam int PIN_COUNT        = 17;
	localparam int SEL_W            = 5;
	localparam int ADDR_W           = 8;
	localparam int DATA_W           = 32;
	localparam int PAD_W            = 16 - CODE_W;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] OFS_CONTROL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_POS_SEL   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_NEG_SEL   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RES_HIGH  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_RES_LOW   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h14;

	// ****************************************************************
	// Control and status register fields
	// ****************************************************************
	localparam int BIT_LEFT_JUSTIFY = 0;
	localparam int BIT_START_BUSY   = 4;
	localparam int BIT_DONE         = 5;
	localparam int BIT_ENABLE       = 7;
	localparam int BIT_DIFF_MODE    = 0;

	// ****************************************************************
	// Select codes and levels
	// ****************************************************************
	localparam logic [SEL_W-1:0] POS_SEL_TEMP   = 5'h1E;
	localparam logic [SEL_W-1:0] POS_SEL_SUPPLY = 5'h1F;
	localparam logic [SEL_W-1:0] NEG_SEL_VREF   = 5'h1E;
	localparam logic [SEL_W-1:0] NEG_SEL_GND    = 5'h1F;
	localparam logic [LEVEL_W-1:0] LEVEL_VREF   = 11'h400;
	localparam logic [LEVEL_W-1:0] LEVEL_GND    = 11'h000;

	// ****************************************************************
	// Reset values and bus responses
	// ****************************************************************
	localparam logic [SEL_W-1:0] SEL_RESET      = 5'h00;
	localparam logic [7:0]       BYTE_RESET     = 8'h00;
	localparam logic [1:0]       RESP_OKAY      = 2'h0;
	localparam logic [1:0]       RESP_SLVERR    = 2'h2;

	typedef logic [CODE_W-1:0] acf_code_type;

endpackage : acf_pkg

// *** design/acf_conv_if.sv ***
// Carrier between the control logic and the conversion engine
`timescale 1ns/10ps
interface acf_conv_if;
	import acf_pkg::*;
	logic         start;
	acf_code_type sample_code;
	logic         busy;
	logic         done;
	acf_code_type result_code;

	modport engine (input start, input sample_code, output busy, output done, output result_code);
	modport ctrl   (output start, output sample_code, input busy, input done, input result_code);
endinterface : acf_conv_if

// *** design/acf_conv_engine.sv ***
// Conversion engine: holds a sampled code for one full conversion period
`timescale 1ns/10ps
module acf_conv_engine
	import acf_pkg::*;
#(
	parameter int CYCLES = acf_pkg::CONV_CYCLES
)
(
	input  wire logic  clock,
	input  wire logic  rst_n,
	input  wire logic  enable,
	acf_conv_if.engine conv
);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	logic [CONV_CNT_W-1:0] count;
	logic [CONV_CNT_W-1:0] next_count;
	logic                  busy;
	logic                  next_busy;
	logic                  done;
	logic                  next_done;
	acf_code_type          code;
	acf_code_type          next_code;

	always_comb
	begin
		next_count = count;
		next_busy  = busy;
		next_done  = 1'b0;
		next_code  = code;
		if (!enable)
		begin
			next_busy  = 1'b0;
			next_count = '0;
		end
		else if (busy)
		begin
			if (count == CONV_CNT_W'(CYCLES - 1))
			begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
			else
			begin
				next_count = count + 1'b1;
			end
		end
		else if (conv.start)
		begin
			next_busy  = 1'b1;
			next_count = '0;
			next_code  = conv.sample_code;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			count <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
			code  <= '0;
		end
		else
		begin
			count <= next_count;
			busy  <= next_busy;
			done  <= next_done;
			code  <= next_code;
		end
	end

	assign conv.busy        = busy;
	assign conv.done        = done;
	assign conv.result_code = code;

endmodule : acf_conv_engine

// *** tb/acf_top_sva.sv ***
// Port checker for the converter control block
`timescale 1ns/10ps
module acf_top_sva
	import acf_pkg::*;
(
	input wire logic				clock,
	input wire logic				rst_n,
	input wire logic [acf_pkg::ADDR_W-1:0]	awaddr,
	input wire logic				awvalid,
	input wire logic				awready,
	input wire logic [acf_pkg::DATA_W-1:0]	wdata,
	input wire logic [3:0]			wstrb,
	input wire logic				wvalid,
	input wire logic				wready,
	input wire logic [1:0]			bresp,
	input wire logic				bvalid,
	input wire logic [acf_pkg::ADDR_W-1:0]	araddr,
	input wire logic				arvalid,
	input wire logic				arready,
	input wire logic [acf_pkg::DATA_W-1:0]	rdata,
	input wire logic [1:0]			rresp,
	input wire logic				rvalid,
	input wire logic				shutdown,
	input wire logic				temp_sensor_route,
	input wire logic				differential_mode
);
	logic [7:0]	aw_q;
	logic [7:0]	ar_q;
	logic [7:0]	wd_q;
	logic		ws_q;
	logic		bv_q;
	logic		lj_q;
	logic		dm_q;
	logic		sd_q;
	logic		commit;

	assign commit = bvalid && !bv_q && ws_q && bresp == RESP_OKAY;

	// Capture of bus traffic and of the mode latched at each start
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			aw_q <= 8'h00;
			ar_q <= 8'h00;
			wd_q <= 8'h00;
			ws_q <= 1'b0;
			bv_q <= 1'b0;
			sd_q <= 1'b1;
			lj_q <= 1'b0;
			dm_q <= 1'b0;
		end
		else
		begin
			bv_q <= bvalid;
			sd_q <= shutdown;
			if (awvalid && awready)
				aw_q <= awaddr;
			if (arvalid && arready)
				ar_q <= araddr;
			if (wvalid && wready)
			begin
				wd_q <= wdata[7:0];
				ws_q <= wstrb[0];
			end
			if (commit && aw_q == OFS_CONTROL && wd_q[BIT_START_BUSY] && wd_q[BIT_ENABLE]
				&& !sd_q)
			begin
				lj_q <= wd_q[BIT_LEFT_JUSTIFY];
				dm_q <= differential_mode;
			end
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	a_reset_state: assert property ($rose(rst_n) |->
		shutdown && differential_mode && !temp_sensor_route) else $error("bad reset outputs");
	a_shutdown_follow: assert property (commit && aw_q == OFS_CONTROL |->
		##2 shutdown == !wd_q[BIT_ENABLE]) else $error("shutdown not following enable");
	a_temp_follow: assert property (commit && aw_q == OFS_POS_SEL |->
		##2 temp_sensor_route == (wd_q[4:0] == POS_SEL_TEMP)) else $error("temp route wrong");
	a_diff_follow: assert property (commit && aw_q == OFS_NEG_SEL |->
		##2 differential_mode == (wd_q[4:0] != NEG_SEL_GND)) else $error("mode wrong");
	a_status_mode: assert property (rvalid && ar_q == OFS_STATUS |->
		rdata == {31'h0, differential_mode}) else $error("status mode wrong");
	a_se_right: assert property (rvalid && ar_q == OFS_RES_HIGH && !dm_q && !lj_q |->
		rdata[7:2] == 6'h00) else $error("unsigned high bits not clear");
	a_diff_right: assert property (rvalid && ar_q == OFS_RES_HIGH && dm_q && !lj_q |->
		rdata[7:2] == {6{rdata[1]}}) else $error("sign extension wrong");
	a_left_low: assert property (rvalid && ar_q == OFS_RES_LOW && lj_q |->
		rdata[5:0] == 6'h00) else $error("left low bits not clear");

	c_start: cover property (commit && aw_q == OFS_CONTROL && wd_q[BIT_START_BUSY]);
	c_diff_read: cover property (rvalid && ar_q == OFS_RES_HIGH && dm_q);
	c_refused: cover property (rvalid && rresp == RESP_SLVERR);
endmodule : acf_top_sva

bind acf_top acf_top_sva u_sva (.clock, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
	.wvalid, .wready, .bresp, .bvalid, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
	.shutdown, .temp_sensor_route, .differential_mode);

// *** tb/tb.sv ***
// Self-checking testbench for the converter control block
`timescale 1ns/10ps
module tb;
	import acf_pkg::*;
	logic							clock = 1'b0;
	logic							rst_n = 1'b0;
	logic [PIN_COUNT-1:0][CODE_W-1:0]	pin_level;
	logic [CODE_W-1:0]				temp_level;
	logic [CODE_W-1:0]				supply_level;
	logic [7:0]						awaddr = 8'h00;
	logic [7:0]						araddr = 8'h00;
	logic [31:0]					wdata = 32'h0000_0000;
	logic [31:0]					rdata;
	logic [31:0]					rq;
	logic [3:0]						wstrb = 4'h0;
	logic [1:0]						bresp;
	logic [1:0]						rresp;
	logic	awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
	logic	awready, wready, bvalid, arready, rvalid;
	logic	shutdown, temp_sensor_route, differential_mode;
	int		n_mismatch = 0;
	int		n_compared = 0;
	int		cyc = 0;

	acf_top u_dut (.clock, .rst_n, .pin_level, .temp_level, .supply_level, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .shutdown, .temp_sensor_route,
		.differential_mode);

	always #25 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic open;
		open = 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (open)
		begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid)
			begin
				chk("bresp", 32'(bresp), 32'(er));
				open = 1'b0;
			end
		end
		@(posedge clock);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [1:0] er, input logic [31:0] e, input string nm);
		logic open;
		open = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		while (open)
		begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid)
			begin
				rq = rdata;
				chk("rresp", 32'(rresp), 32'(er));
				open = 1'b0;
			end
		end
		if (nm != "") chk(nm, rq, e);
	endtask : rdc

	task conv(input logic [4:0] p, input logic [4:0] n, input logic lj, input logic [15:0] e);
		int t0;
		wr(OFS_POS_SEL, 32'(p), 4'h1, RESP_OKAY);
		wr(OFS_NEG_SEL, 32'(n), 4'h1, RESP_OKAY);
		wr(OFS_CONTROL, 32'h0000_0080 + 32'(lj), 4'h1, RESP_OKAY);
		t0 = cyc;
		wr(OFS_CONTROL, 32'h0000_0090 + 32'(lj), 4'h1, RESP_OKAY);
		rdc(OFS_CONTROL, RESP_OKAY, 32'h0000_0090 + 32'(lj), "busy");
		while (!rq[BIT_DONE]) rdc(OFS_CONTROL, RESP_OKAY, 0, "");
		chk("done", 32'(rq[BIT_DONE]), 1);
		chk("rate", 32'(cyc - t0 >= CLOCK_HZ / (MAX_RATE_KSPS * 1000)), 1);
		rdc(OFS_RES_HIGH, RESP_OKAY, 32'(e[15:8]), "res_high");
		rdc(OFS_RES_LOW, RESP_OKAY, 32'(e[7:0]), "res_low");
	endtask : conv

	task t_reset;
		chk("shutdown", 32'(shutdown), 1);
		chk("diff_mode", 32'(differential_mode), 1);
		chk("temp_route", 32'(temp_sensor_route), 0);
		rdc(OFS_CONTROL, RESP_OKAY, 0, "control");
		rdc(8'h18, RESP_SLVERR, 0, "unmapped");
		wr(8'h18, 32'h0000_0080, 4'h1, RESP_SLVERR);
		wr(OFS_CONTROL, 32'h0000_0090, 4'h1, RESP_OKAY);
		rdc(OFS_CONTROL, RESP_OKAY, 32'h0000_0080, "late_start");
		chk("shutdown", 32'(shutdown), 0);
	endtask : t_reset

	task t_select;
		wr(OFS_POS_SEL, 32'(POS_SEL_TEMP), 4'h1, RESP_OKAY);
		chk("temp_route", 32'(temp_sensor_route), 1);
		wr(OFS_POS_SEL, 32'(POS_SEL_SUPPLY), 4'h1, RESP_OKAY);
		chk("temp_route", 32'(temp_sensor_route), 0);
		wr(OFS_NEG_SEL, 32'(NEG_SEL_GND), 4'h1, RESP_OKAY);
		chk("diff_mode", 32'(differential_mode), 0);
		rdc(OFS_STATUS, RESP_OKAY, 0, "status");
		wr(OFS_NEG_SEL, 32'(NEG_SEL_VREF), 4'h0, RESP_OKAY);
		chk("diff_mode", 32'(differential_mode), 0);
		wr(OFS_NEG_SEL, 32'(NEG_SEL_VREF), 4'h1, RESP_OKAY);
		rdc(OFS_STATUS, RESP_OKAY, 1, "status");
		wr(OFS_RES_HIGH, 32'h0000_00FF, 4'h1, RESP_OKAY);
		rdc(OFS_RES_HIGH, RESP_OKAY, 0, "read_only");
	endtask : t_select

	task t_format;
		conv(5'h1F, 5'h1F, 1'b0, 16'h03FF);
		conv(5'h1F, 5'h1F, 1'b1, 16'hFFC0);
		conv(POS_SEL_TEMP, 5'h1F, 1'b1, 16'h8000);
		conv(5'h11, NEG_SEL_VREF, 1'b0, 16'hFE00);
		conv(5'h11, NEG_SEL_VREF, 1'b1, 16'h8000);
		conv(5'h1F, 5'h00, 1'b0, 16'h01FF);
		conv(5'h1F, 5'h00, 1'b1, 16'h7FC0);
		conv(5'h00, 5'h08, 1'b0, 16'hFF10);
		conv(5'h00, 5'h08, 1'b1, 16'hC400);
	endtask : t_format

	task t_inputs;
		for (int k = 0; k < PIN_COUNT; k++) conv(5'(k), 5'h1F, 1'b0, 16'(k * 60));
		for (int k = 0; k < PIN_COUNT; k++) conv(5'h1F, 5'(k), 1'b0, 16'((1023 - k * 60) / 2));
	endtask : t_inputs

	task t_abort;
		wr(OFS_CONTROL, 32'h0000_0080, 4'h1, RESP_OKAY);
		wr(OFS_CONTROL, 32'h0000_0090, 4'h1, RESP_OKAY);
		wr(OFS_CONTROL, 32'h0000_0000, 4'h1, RESP_OKAY);
		repeat (110) @(posedge clock);
		chk("shutdown", 32'(shutdown), 1);
		rdc(OFS_CONTROL, RESP_OKAY, 0, "aborted");
		rdc(OFS_RES_LOW, RESP_OKAY, 32'h0000_001F, "kept");
	endtask : t_abort

	task results;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	initial
	begin
		@(posedge clock);
		for (int k = 0; k < PIN_COUNT; k++) pin_level[k] <= 10'(k * 60);
		temp_level <= 10'h200;
		supply_level <= 10'h3FF;
		repeat (7) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_select();
		t_format();
		t_inputs();
		t_abort();
		results();
	end

	initial
	begin
		repeat (40000) @(posedge clock);
		n_mismatch++;
		results();
	end
endmodule : tb
